// ==== hdl/amc_defines.svh ====
// Register offsets, field positions and reset values of the analog module control block.
`ifndef AMC_DEFINES_SVH
`define AMC_DEFINES_SVH

`define AMC_ADDR_W            8
`define AMC_DATA_W            8
`define AMC_OFS_SLEEP_CTRL    8'h00
`define AMC_OFS_CONV_CTRL0    8'h01
`define AMC_OFS_CMP_CTRL      8'h02
`define AMC_OFS_PERIPH_REQ1   8'h03
`define AMC_OFS_PERIPH_EN1    8'h04
`define AMC_OFS_INT_CTRL      8'h05
`define AMC_OFS_CHAN_SEL      8'h06
`define AMC_SLP_TEMP_OFF_BIT  1
`define AMC_SLP_CMP_OFF_BIT   2
`define AMC_SLP_LS_OFF_BIT    4
`define AMC_SLP_BG_OFF_BIT    5
`define AMC_CV0_ZERO_BIT      0
`define AMC_CMP_A_POL_BIT     0
`define AMC_CMP_A_PIN_BIT     1
`define AMC_CMP_A_STATE_BIT   2
`define AMC_CMP_B_POL_BIT     4
`define AMC_CMP_B_PIN_BIT     5
`define AMC_CMP_B_STATE_BIT   6
`define AMC_CMP_WR_MASK       8'h33
`define AMC_IRQ_BIT           7
`define AMC_INT_GLOBAL_BIT    7
`define AMC_INT_PERIPH_BIT    6
`define AMC_CHAN_BANDGAP      4'h4
`define AMC_CHAN_TEMP         4'h7
`define AMC_RST_BYTE          8'h00
`define AMC_RST_CHAN          4'h0

`endif

// ==== hdl/amc_pkg.sv ====
// Types shared by the analog module control block.
package amc_pkg;
  `include "amc_defines.svh"

  typedef logic [`AMC_ADDR_W-1:0] amc_addr_t;
  typedef logic [`AMC_DATA_W-1:0] amc_data_t;

  typedef struct packed {
    amc_addr_t addr;
    amc_data_t wdata;
    logic      wr;
    logic      rd;
  } amc_bus_req_s;

  typedef struct packed {
    logic bandgap_en;
    logic level_shift_en;
    logic temp_sensor_en;
    logic comparator_en;
    logic zero_gate_sel;
    logic filter_switch_closed;
    logic cmp_b_input_sel;
    logic route_bandgap;
    logic route_temp;
  } amc_analog_ctrl_s;

  typedef struct packed {
    logic cmp_a_pin_oe;
    logic cmp_a_pin_val;
    logic cmp_b_pin_oe;
    logic cmp_b_pin_val;
    logic ref_b_pin_en;
  } amc_pin_ctrl_s;

  typedef struct packed {
    amc_data_t sleep_control_reg;
    amc_data_t converter_control_reg0;
    amc_data_t comparator_control_reg;
    logic      comparator_irq_flag;
    logic      comparator_irq_enable;
    logic      global_enable;
    logic      periph_enable;
    logic [3:0] chan_sel;
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    amc_data_t rdata;
  } amc_state_s;
endpackage : amc_pkg

// ==== hdl/amc_ctrl.sv ====
// Digital control of the bandgap, level-shift, temperature sensor and comparator modules.
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "amc_defines.svh"

// Function
// - Bandgap reference powered only while bandgap_off (sleep bit 5) is clear.
// - Channel 4 selection routes bandgap voltage to the converter.
// - Level-shift networks enabled while level_shift_off (sleep bit 4) is clear.
// - Converter zeroing bit 0 switches pass gates to present zero-current input.
// - Filter switch closed while sampling, forced open while zeroing.
// - Channel 7 selection routes temperature sensor voltage to the converter.
// - Temperature sensor enabled only while temp_sensor_off (sleep bit 1) is clear.
// - After reset input one feeds both comparators for window comparison.
// - Comparator B pin enable (bit 5) makes comparator B watch input five.
// - Comparator states read at bits 2 and 6; writes there are ignored.
// - Polarity bits 0 and 4 choose whether a high or a low comparator state interrupts.
// - Irq flag (request bit 7) sets when any state XOR polarity is one.
// - Irq reaches core only with enable bit 7 and interrupt bits 7:6 set.
// - Condition is level sensitive; flag sets again each cycle while condition holds.
// - Pin enable bits 1 and 5 drive comparator outputs onto pins, overriding direction.
// - References and comparators enabled only while comparator_off (sleep bit 2) is clear.
// - With comparator B pin enable clear, its pins return to port function.
module amc_ctrl (
  // Clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      rst_n_in,
  // Register port
  input  wire amc_pkg::amc_bus_req_s     bus_in,
  output logic      [`AMC_DATA_W-1:0]    rdata_out,
  // Converter sampling window and raw comparator outputs
  input  wire logic                      sampling_in,
  input  wire logic                      comparator_a_raw_in,
  input  wire logic                      comparator_b_raw_in,
  // Analog control and pin overrides
  output amc_pkg::amc_analog_ctrl_s      analog_out,
  output amc_pkg::amc_pin_ctrl_s         pins_out,
  // Interrupt request to the core
  output logic                           irq_out
);
  import amc_pkg::*;

  amc_state_s state;
  amc_state_s next_state;
  logic       cmp_a_state;
  logic       cmp_b_state;
  logic       irq_cond;

  // Only the second flop of each synchroniser is read.
  assign cmp_a_state = state.sync_a[1];
  assign cmp_b_state = state.sync_b[1];

  assign irq_cond = (cmp_a_state ^ state.comparator_control_reg[`AMC_CMP_A_POL_BIT]) |
                    (cmp_b_state ^ state.comparator_control_reg[`AMC_CMP_B_POL_BIT]);

  always_comb begin
    next_state = state;
    next_state.sync_a = {state.sync_a[0], comparator_a_raw_in};
    next_state.sync_b = {state.sync_b[0], comparator_b_raw_in};
    next_state.rdata = `AMC_RST_BYTE;

    if (bus_in.wr) begin
      if (bus_in.addr == `AMC_OFS_SLEEP_CTRL) begin
        next_state.sleep_control_reg = bus_in.wdata;
      end else if (bus_in.addr == `AMC_OFS_CONV_CTRL0) begin
        next_state.converter_control_reg0 = bus_in.wdata;
      end else if (bus_in.addr == `AMC_OFS_CMP_CTRL) begin
        // State bits are not writable.
        next_state.comparator_control_reg = bus_in.wdata & `AMC_CMP_WR_MASK;
      end else if (bus_in.addr == `AMC_OFS_PERIPH_REQ1) begin
        next_state.comparator_irq_flag = bus_in.wdata[`AMC_IRQ_BIT];
      end else if (bus_in.addr == `AMC_OFS_PERIPH_EN1) begin
        next_state.comparator_irq_enable = bus_in.wdata[`AMC_IRQ_BIT];
      end else if (bus_in.addr == `AMC_OFS_INT_CTRL) begin
        next_state.global_enable = bus_in.wdata[`AMC_INT_GLOBAL_BIT];
        next_state.periph_enable = bus_in.wdata[`AMC_INT_PERIPH_BIT];
      end else if (bus_in.addr == `AMC_OFS_CHAN_SEL) begin
        next_state.chan_sel = bus_in.wdata[3:0];
      end
    end

    // A live condition wins over a software clear in the same cycle.
    if (irq_cond) begin
      next_state.comparator_irq_flag = 1'b1;
    end

    if (bus_in.rd) begin
      if (bus_in.addr == `AMC_OFS_SLEEP_CTRL) begin
        next_state.rdata = state.sleep_control_reg;
      end else if (bus_in.addr == `AMC_OFS_CONV_CTRL0) begin
        next_state.rdata = state.converter_control_reg0;
      end else if (bus_in.addr == `AMC_OFS_CMP_CTRL) begin
        next_state.rdata = state.comparator_control_reg;
        next_state.rdata[`AMC_CMP_A_STATE_BIT] = cmp_a_state;
        next_state.rdata[`AMC_CMP_B_STATE_BIT] = cmp_b_state;
      end else if (bus_in.addr == `AMC_OFS_PERIPH_REQ1) begin
        next_state.rdata[`AMC_IRQ_BIT] = state.comparator_irq_flag;
      end else if (bus_in.addr == `AMC_OFS_PERIPH_EN1) begin
        next_state.rdata[`AMC_IRQ_BIT] = state.comparator_irq_enable;
      end else if (bus_in.addr == `AMC_OFS_INT_CTRL) begin
        next_state.rdata[`AMC_INT_GLOBAL_BIT] = state.global_enable;
        next_state.rdata[`AMC_INT_PERIPH_BIT] = state.periph_enable;
      end else if (bus_in.addr == `AMC_OFS_CHAN_SEL) begin
        next_state.rdata = {4'h0, state.chan_sel};
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state.sleep_control_reg      <= `AMC_RST_BYTE;
      state.converter_control_reg0 <= `AMC_RST_BYTE;
      state.comparator_control_reg <= `AMC_RST_BYTE;
      state.comparator_irq_flag    <= 1'b0;
      state.comparator_irq_enable  <= 1'b0;
      state.global_enable          <= 1'b0;
      state.periph_enable          <= 1'b0;
      state.chan_sel               <= `AMC_RST_CHAN;
      state.sync_a                 <= 2'h0;
      state.sync_b                 <= 2'h0;
      state.rdata                  <= `AMC_RST_BYTE;
    end else begin
      state <= next_state;
    end
  end

  assign rdata_out = state.rdata;

  // Enables are driven straight from the stored control bits so that the analog side sees no glitches.
  always_comb begin
    analog_out.bandgap_en     = ~state.sleep_control_reg[`AMC_SLP_BG_OFF_BIT];
    analog_out.level_shift_en = ~state.sleep_control_reg[`AMC_SLP_LS_OFF_BIT];
    analog_out.temp_sensor_en = ~state.sleep_control_reg[`AMC_SLP_TEMP_OFF_BIT];
    analog_out.comparator_en  = ~state.sleep_control_reg[`AMC_SLP_CMP_OFF_BIT];
    analog_out.zero_gate_sel  = state.converter_control_reg0[`AMC_CV0_ZERO_BIT];
    analog_out.filter_switch_closed = sampling_in &
                                      ~state.converter_control_reg0[`AMC_CV0_ZERO_BIT];
    // Low selects input one for comparator B (window mode), high selects input five.
    analog_out.cmp_b_input_sel = state.comparator_control_reg[`AMC_CMP_B_PIN_BIT];
    analog_out.route_bandgap   = (state.chan_sel == `AMC_CHAN_BANDGAP);
    analog_out.route_temp      = (state.chan_sel == `AMC_CHAN_TEMP);
  end

  always_comb begin
    pins_out.cmp_a_pin_oe  = state.comparator_control_reg[`AMC_CMP_A_PIN_BIT];
    pins_out.cmp_a_pin_val = cmp_a_state;
    pins_out.cmp_b_pin_oe  = state.comparator_control_reg[`AMC_CMP_B_PIN_BIT];
    pins_out.cmp_b_pin_val = cmp_b_state;
    pins_out.ref_b_pin_en  = state.comparator_control_reg[`AMC_CMP_B_PIN_BIT];
  end

  assign irq_out = state.comparator_irq_flag & state.comparator_irq_enable &
                   state.global_enable & state.periph_enable;
endmodule : amc_ctrl
`default_nettype wire

// ==== bench/amc_ctrl_chk.sv ====
// Concurrent checks on the ports of the analog module control block.
`timescale 1ns/100ps
`default_nettype none
module amc_ctrl_chk (
  // Watched ports
  input wire logic                      clk_in,
  input wire logic                      rst_n_in,
  input wire amc_pkg::amc_bus_req_s     bus_in,
  input wire logic [7:0]                rdata_out,
  input wire logic                      sampling_in,
  input wire logic                      comparator_a_raw_in,
  input wire amc_pkg::amc_analog_ctrl_s analog_out,
  input wire amc_pkg::amc_pin_ctrl_s    pins_out
);
  import amc_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire logic [7:0] d = bus_in.wdata;
  a_sleep_ens: assert property (bus_in.wr && bus_in.addr == 8'h00 |=>
    analog_out[8:5] == ~{$past(d[5]), $past(d[4]), $past(d[1]), $past(d[2])}) else $error("enable bits wrong");
  a_zero_gate: assert property (bus_in.wr && bus_in.addr == 8'h01 |=>
    analog_out.zero_gate_sel == $past(d[0])) else $error("zero gate wrong");
  a_filter_sw: assert property (analog_out.filter_switch_closed ==
    (sampling_in && !analog_out.zero_gate_sel)) else $error("filter switch wrong");
  a_chan_route: assert property (bus_in.wr && bus_in.addr == 8'h06 |=>
    analog_out[1:0] == {$past(d[3:0]) == 4'h4, $past(d[3:0]) == 4'h7}) else $error("routing wrong");
  a_b_input_sel: assert property (bus_in.wr && bus_in.addr == 8'h02 |=>
    {analog_out.cmp_b_input_sel, pins_out.cmp_a_pin_oe, pins_out.cmp_b_pin_oe, pins_out.ref_b_pin_en} ==
    {$past(d[5]), $past(d[1]), $past(d[5]), $past(d[5])}) else $error("pin routing wrong");
  a_state_read: assert property (bus_in.rd && bus_in.addr == 8'h02 |=>
    {rdata_out[7:6], rdata_out[3:2]} == {1'b0, $past(pins_out[1]), 1'b0, $past(pins_out[3])}) else $error("status read wrong");
  a_sync_two: assert property ($rose(comparator_a_raw_in) ##0 comparator_a_raw_in[*3] |->
    pins_out.cmp_a_pin_val) else $error("sync latency wrong");
  a_rd_idle: assert property (!bus_in.rd |=> rdata_out == 8'h00) else $error("read data not idle");
endmodule : amc_ctrl_chk
bind amc_ctrl amc_ctrl_chk chk_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus_in(bus_in), .rdata_out(rdata_out),
  .sampling_in(sampling_in), .comparator_a_raw_in(comparator_a_raw_in), .analog_out(analog_out), .pins_out(pins_out));
`default_nettype wire

// ==== bench/amc_cmp_model.sv ====
// Behavioural model of the two unclocked analog comparators.
`timescale 1ns/100ps
`default_nettype none
module amc_cmp_model (
  // Levels set by the bench
  input  wire logic a_level_in,
  input  wire logic b_level_in,
  // Comparator outputs
  output logic      a_out,
  output logic      b_out
);
  // Odd delays keep output edges off the clock grid, as a real comparator would.
  initial {a_out, b_out} = 2'b00;
  always @(a_level_in) a_out <= #7 a_level_in;
  always @(b_level_in) b_out <= #11 b_level_in;
endmodule : amc_cmp_model
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench for the analog module control block.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import amc_pkg::*;
  typedef struct packed { logic [7:0] a, d; logic s; logic [8:0] e; } amc_row_s;
  logic clk_in = 0, rst_n_in = 0, samp = 0, lva = 0, lvb = 0, ra, rb, irq;
  amc_bus_req_s bus = '0;
  logic [7:0] rdata;
  amc_analog_ctrl_s an;
  amc_pin_ctrl_s pins;
  int num_errors = 0, cmp_count = 0, cyc = 0;
  amc_row_s rows [9] = '{'{8'h00, 8'h20, 1, 9'h0e8}, '{8'h00, 8'h16, 1, 9'h108}, '{8'h01, 8'h01, 1, 9'h110},
    '{8'h06, 8'h04, 0, 9'h112}, '{8'h06, 8'h07, 1, 9'h111}, '{8'h01, 8'h00, 1, 9'h109},
    '{8'h02, 8'h20, 0, 9'h105}, '{8'h00, 8'h00, 0, 9'h1e5}, '{8'h07, 8'hff, 1, 9'h1ed}};
  amc_ctrl dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus_in(bus), .rdata_out(rdata), .sampling_in(samp),
    .comparator_a_raw_in(ra), .comparator_b_raw_in(rb), .analog_out(an), .pins_out(pins), .irq_out(irq));
  amc_cmp_model cmp_u (.a_level_in(lva), .b_level_in(lvb), .a_out(ra), .b_out(rb));
  always #12.5 clk_in = ~clk_in;
  always @(posedge clk_in) if (++cyc == 3000) begin
    num_errors++;
    final_report();
  end
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic chk(input logic [8:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_in) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_in) bus <= '0;
    #1;
  endtask : wr
  // A read only compares in the single cycle where read data stand.
  task automatic chk_rd(input logic [7:0] a, e);
    @(posedge clk_in) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_in) bus <= '0;
    #1 chk({1'b0, rdata}, {1'b0, e});
  endtask : chk_rd
  task automatic w(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : w
  initial begin
    w(20);
    rst_n_in <= 1'b1;
    w(1);
    chk(an, 9'h1e0);
    chk({4'h0, pins}, 9'h000);
    chk_rd(8'h02, 8'h00);
    $display("reset test done");
    foreach (rows[i]) begin
      @(posedge clk_in) samp <= rows[i].s;
      wr(rows[i].a, rows[i].d);
      chk(an, rows[i].e);
    end
    $display("table test done");
    wr(8'h02, 8'hff);
    chk_rd(8'h02, 8'h33);
    @(posedge clk_in) lva <= 1'b1;
    w(5);
    chk_rd(8'h02, 8'h37);
    @(posedge clk_in) lvb <= 1'b1;
    w(5);
    chk_rd(8'h02, 8'h77);
    chk({4'h0, pins}, 9'h01f);
    $display("comparator test done");
    wr(8'h04, 8'h80);
    wr(8'h05, 8'hc0);
    wr(8'h03, 8'h00);
    w(3);
    chk({8'h00, irq}, 9'h000);
    wr(8'h02, 8'h22);
    w(3);
    chk({8'h00, irq}, 9'h001);
    wr(8'h03, 8'h00);
    chk_rd(8'h03, 8'h80);
    wr(8'h05, 8'h80);
    chk({8'h00, irq}, 9'h000);
    wr(8'h05, 8'h40);
    chk({8'h00, irq}, 9'h000);
    wr(8'h05, 8'hc0);
    wr(8'h04, 8'h00);
    chk({8'h00, irq}, 9'h000);
    wr(8'h02, 8'h33);
    wr(8'h03, 8'h00);
    w(2);
    chk_rd(8'h03, 8'h00);
    @(posedge clk_in) lva <= 1'b0;
    w(5);
    chk_rd(8'h03, 8'h80);
    chk_rd(8'h07, 8'h00);
    wr(8'h02, 8'h02);
    chk({4'h0, pins}, 9'h012);
    $display("interrupt test done");
    final_report();
  end
endmodule : tb
`default_nettype wire
